// ### design/acrb_config_banks.sv
// configuration register bank with eight-bank ram, linear pointer, bank copies and checksums
`timescale 1ns/1ps
module acrb_config_banks
   import acrb_pkg::*;
#(
   parameter int GPIO_WIDTH = 8
) (
   input wire logic sys_clk, // 40 MHz core clock
   input wire logic nrst, // async reset, active low
   input wire logic [2:0] factory_id, // factory id strap
   input wire logic data_ready_n, // data ready pin level, active low
   input wire logic reg_wr, // register write strobe
   input wire logic reg_rd, // register read strobe
   input wire logic [3:0] reg_addr, // register offset
   input wire logic [7:0] reg_wdata, // register write byte
   output logic [7:0] reg_rdata, // register read byte
   input wire logic ram_load_ptr, // load ram pointer
   input wire logic [7:0] ram_ptr_addr, // linear address to load
   input wire logic ram_wr, // ram write strobe, pointer advances
   input wire logic ram_rd, // ram read strobe, pointer advances
   input wire logic [7:0] ram_wdata, // ram write byte
   output logic [7:0] ram_rdata, // ram read byte
   output logic [7:0] ram_ptr, // current linear pointer
   input wire logic copy_reg_to_ram, // copy registers to bank
   input wire logic copy_reg_to_all, // copy registers to every bank
   input wire logic copy_ram_to_reg, // copy bank to registers
   input wire logic [2:0] op_bank, // bank for copy or checksum
   input wire logic csum_start, // start checksum
   input wire logic [1:0] csum_kind, // checksum scope
   output logic [7:0] csum_value, // last checksum result
   output logic busy, // copy or checksum in progress
   output logic mod_div_256, // modulator divider is 256
   output logic [8:0] mod_div, // modulator divide ratio
   output logic ref_enable, // internal reference enable
   output logic reference_level_select, // 1 = 2.5 V, 0 = 1.25 V
   output logic buffer_enable, // input buffer enable
   output logic out_lsb_first, // output bit order within byte
   output logic [3:0] positive_input_select, // positive mux code
   output logic [3:0] negative_input_select, // negative mux code
   output logic [3:0] pos_channel, // decoded positive channel
   output logic pos_common, // positive is common input
   output logic pos_diode_anode, // positive is diode anode
   output logic [3:0] neg_channel, // decoded negative channel
   output logic neg_common, // negative is common input
   output logic neg_diode_cathode, // negative is diode cathode
   output logic burnout_source_on, // burnout sources enabled
   output logic [1:0] source_two_range, // range of source 2, 0 off
   output logic [1:0] source_one_range, // range of source 1, 0 off
   output logic [2:0] gain_select, // gain code
   output logic [7:0] gain_value, // gain 1..128
   output logic [7:0] current_source_one_code, // dac 1 code
   output logic [7:0] current_source_two_code, // dac 2 code
   output logic offset_negative, // offset sign
   output logic [6:0] offset_magnitude, // offset code out of 127
   output logic [10:0] decimation, // decimation ratio
   output logic [1:0] settling_filter_select, // filter mode
   output logic unipolar, // data format
   output logic [23:0] offset_coeff, // offset calibration word
   output logic [23:0] gain_coeff, // full-scale calibration word
   input wire logic [GPIO_WIDTH-1:0] gpio_in, // gpio pin levels
   output logic [GPIO_WIDTH-1:0] gpio_out, // gpio drive value
   output logic [GPIO_WIDTH-1:0] gpio_oe // gpio output enable, high drives
);
   //--------------------------------------------------
   // storage
   //--------------------------------------------------
   logic [7:0] regs_ff [NUM_REGS];
   logic [7:0] ram_ff [RAM_BYTES];
   logic [2:0] id_ff;
   logic [7:0] ptr_ff;
   logic [7:0] ram_rdata_ff;
   logic [7:0] reg_rdata_ff;
   logic [7:0] csum_ff;
   logic [7:0] acc_ff;
   logic [6:0] idx_ff;
   logic [6:0] last_ff;
   logic from_regs_ff;
   logic all_ff;
   logic dir_ram_ff;
   logic [2:0] bank_ff;
   acrb_state_e state_ff;
   logic [GPIO_WIDTH-1:0] gpio_s1_ff, gpio_s2_ff, gpio_s3_ff, gpio_ff;
   logic [2:0] rdy_s_ff;
   logic rdy_ff;

   function automatic logic [7:0] gain_of(input logic [2:0] code);
      gain_of = 8'h01 << code;
   endfunction

   //--------------------------------------------------
   // pin synchronisers
   //--------------------------------------------------
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         gpio_s1_ff <= '0;
         gpio_s2_ff <= '0;
         gpio_s3_ff <= '0;
         gpio_ff <= '0;
         rdy_s_ff <= 3'h7;
         rdy_ff <= 1'b1;
      end else begin
         gpio_s1_ff <= gpio_in;
         gpio_s2_ff <= gpio_s1_ff;
         gpio_s3_ff <= gpio_s2_ff;
         for (int b = 0; b < GPIO_WIDTH; b++) begin
            if (gpio_s2_ff[b] == gpio_s3_ff[b]) begin
               gpio_ff[b] <= gpio_s3_ff[b];
            end
         end
         rdy_s_ff <= {rdy_s_ff[1:0], data_ready_n};
         if (rdy_s_ff[1] == rdy_s_ff[2]) begin
            rdy_ff <= rdy_s_ff[2];
         end
      end
   end

   //--------------------------------------------------
   // decode
   //--------------------------------------------------
   wire logic idle = (state_ff == acrb_idle_e);
   wire logic host_reg_wr = reg_wr && idle;
   wire logic host_ram_acc = (ram_wr || ram_rd) && idle;
   wire logic [3:0] ptr_bank = {1'b0, ptr_ff[6:4]};
   wire logic [3:0] ptr_ofs = ptr_ff[3:0];
   wire logic [6:0] ptr_idx = {ptr_bank[2:0], ptr_ofs};
   wire logic [7:0] ptr_next = {1'b0, 7'(ptr_ff[6:0] + 7'd1)};
   wire logic [3:0] step_ofs = idx_ff[3:0];
   wire logic [7:0] step_byte = from_regs_ff ? regs_ff[step_ofs] : ram_ff[idx_ff];
   // reads show live pins on the port register, not the stored drive value
   wire logic [7:0] reg_view = (reg_addr == OFS_GPIO_VALUE) ? 8'(gpio_ff) : regs_ff[reg_addr];
   wire logic [7:0] setup_live = {id_ff, regs_ff[OFS_SETUP_CONFIG][4:0]};
   wire logic [7:0] mode_live = {~rdy_ff, regs_ff[OFS_MODE_DECIMATION_HIGH][6:0]};
   wire logic [7:0] reg_out = (reg_addr == OFS_SETUP_CONFIG) ? setup_live :
      (reg_addr == OFS_MODE_DECIMATION_HIGH) ? mode_live : reg_view;

   //--------------------------------------------------
   // register file
   //--------------------------------------------------
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         for (int r = 0; r < NUM_REGS; r++) begin
            regs_ff[r] <= RST_ZERO;
         end
         regs_ff[OFS_SETUP_CONFIG] <= {3'h0, RST_SETUP_LOW};
         regs_ff[OFS_INPUT_SELECT] <= RST_INPUT_SELECT;
         regs_ff[OFS_GPIO_DIRECTION] <= RST_GPIO_DIRECTION;
         regs_ff[OFS_DECIMATION_LOW] <= RST_DECIMATION_LOW;
         regs_ff[OFS_MODE_DECIMATION_HIGH] <= RST_MODE_DECIMATION_HIGH;
         regs_ff[OFS_GAIN_COEFF_LOW] <= RST_GAIN_COEFF_LOW;
         regs_ff[OFS_GAIN_COEFF_MID] <= RST_GAIN_COEFF_MID;
         regs_ff[OFS_GAIN_COEFF_HIGH] <= RST_GAIN_COEFF_HIGH;
         reg_rdata_ff <= RST_ZERO;
      end else begin
         if (host_reg_wr) begin
            regs_ff[reg_addr] <= reg_wdata;
         end else if (state_ff == acrb_copy_e && dir_ram_ff) begin
            regs_ff[step_ofs] <= ram_ff[idx_ff];
         end
         if (reg_rd) begin
            reg_rdata_ff <= reg_out;
         end
      end
   end

   // factory id has no reset; it is loaded from the pin on every clock, under reset as well
   always_ff @(posedge sys_clk) begin
      id_ff <= factory_id;
   end

   //--------------------------------------------------
   // ram and pointer
   //--------------------------------------------------
   always_ff @(posedge sys_clk) begin
      if (host_ram_acc && ram_wr) begin
         ram_ff[ptr_idx] <= ram_wdata;
      end else if (state_ff == acrb_copy_e && !dir_ram_ff) begin
         ram_ff[idx_ff] <= regs_ff[step_ofs];
      end
   end

   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         ptr_ff <= 8'h00;
         ram_rdata_ff <= 8'h00;
      end else begin
         if (ram_load_ptr && idle) begin
            ptr_ff <= {1'b0, ram_ptr_addr[6:0]};
         end else if (host_ram_acc) begin
            ptr_ff <= ptr_next;
         end
         if (host_ram_acc && ram_rd) begin
            ram_rdata_ff <= ram_ff[ptr_idx];
         end
      end
   end

   //--------------------------------------------------
   // bank copy and checksum sequencer
   //--------------------------------------------------
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         state_ff <= acrb_idle_e;
         idx_ff <= 7'h00;
         last_ff <= 7'h00;
         from_regs_ff <= 1'b0;
         all_ff <= 1'b0;
         dir_ram_ff <= 1'b0;
         bank_ff <= 3'h0;
         acc_ff <= 8'h00;
         csum_ff <= 8'h00;
      end else begin
         case (state_ff)
            acrb_idle_e: begin
               bank_ff <= op_bank;
               acc_ff <= 8'h00;
               if (copy_reg_to_ram || copy_reg_to_all || copy_ram_to_reg) begin
                  state_ff <= acrb_copy_e;
                  dir_ram_ff <= copy_ram_to_reg && !copy_reg_to_ram && !copy_reg_to_all;
                  all_ff <= copy_reg_to_all;
                  from_regs_ff <= 1'b1;
                  idx_ff <= copy_reg_to_all ? 7'h00 : {op_bank, 4'h0};
                  last_ff <= copy_reg_to_all ? 7'h7F : {op_bank, 4'hF};
               end else if (csum_start) begin
                  state_ff <= acrb_csum_e;
                  from_regs_ff <= (csum_kind == CSUM_REGS);
                  idx_ff <= (csum_kind == CSUM_ONE_BANK) ? {op_bank, 4'h0} : 7'h00;
                  last_ff <= (csum_kind == CSUM_ONE_BANK) ? {op_bank, 4'hF} :
                     (csum_kind == CSUM_REGS) ? 7'h0F : 7'h7F;
               end
            end
            acrb_copy_e: begin
               idx_ff <= 7'(idx_ff + 7'd1);
               if (idx_ff == last_ff) begin
                  state_ff <= acrb_idle_e;
               end
            end
            acrb_csum_e: begin
               acc_ff <= 8'(acc_ff + step_byte);
               idx_ff <= 7'(idx_ff + 7'd1);
               if (idx_ff == last_ff) begin
                  csum_ff <= 8'(acc_ff + step_byte);
                  state_ff <= acrb_idle_e;
               end
            end
            default: state_ff <= acrb_idle_e;
         endcase
      end
   end

   //--------------------------------------------------
   // outputs
   //--------------------------------------------------
   // only configuration is mapped; conversion results live elsewhere
   assign reg_rdata = reg_rdata_ff;
   assign ram_rdata = ram_rdata_ff;
   assign ram_ptr = ptr_ff;
   assign csum_value = csum_ff;
   assign busy = !idle;
   assign mod_div_256 = regs_ff[OFS_SETUP_CONFIG][SETUP_SPEED_BIT];
   assign mod_div = mod_div_256 ? MOD_DIV_SLOW : MOD_DIV_FAST;
   assign ref_enable = regs_ff[OFS_SETUP_CONFIG][SETUP_REF_EN_BIT];
   assign reference_level_select = regs_ff[OFS_SETUP_CONFIG][SETUP_REF_LEVEL_BIT];
   assign buffer_enable = regs_ff[OFS_SETUP_CONFIG][SETUP_BUF_EN_BIT];
   assign out_lsb_first = regs_ff[OFS_SETUP_CONFIG][SETUP_BIT_ORDER_BIT];
   assign positive_input_select = regs_ff[OFS_INPUT_SELECT][7:4];
   assign negative_input_select = regs_ff[OFS_INPUT_SELECT][3:0];
   assign pos_channel = {1'b0, positive_input_select[2:0]};
   assign pos_diode_anode = (positive_input_select == MUX_DIODE);
   assign pos_common = positive_input_select[3] && !pos_diode_anode;
   assign neg_channel = {1'b0, negative_input_select[2:0]};
   assign neg_diode_cathode = (negative_input_select == MUX_DIODE);
   assign neg_common = negative_input_select[3] && !neg_diode_cathode;
   assign burnout_source_on = regs_ff[OFS_ANALOG_CONTROL][7];
   assign source_two_range = regs_ff[OFS_ANALOG_CONTROL][6:5];
   assign source_one_range = regs_ff[OFS_ANALOG_CONTROL][4:3];
   assign gain_select = regs_ff[OFS_ANALOG_CONTROL][2:0];
   assign gain_value = gain_of(gain_select);
   assign current_source_one_code = regs_ff[OFS_CURRENT_SOURCE_ONE_CODE];
   assign current_source_two_code = regs_ff[OFS_CURRENT_SOURCE_TWO_CODE];
   assign offset_negative = regs_ff[OFS_INPUT_OFFSET_SETTING][7];
   assign offset_magnitude = regs_ff[OFS_INPUT_OFFSET_SETTING][6:0];
   assign decimation = {regs_ff[OFS_MODE_DECIMATION_HIGH][2:0], regs_ff[OFS_DECIMATION_LOW]};
   assign settling_filter_select = regs_ff[OFS_MODE_DECIMATION_HIGH][5:4];
   assign unipolar = regs_ff[OFS_MODE_DECIMATION_HIGH][6];
   assign offset_coeff = {regs_ff[OFS_OFFSET_COEFF_HIGH], regs_ff[OFS_OFFSET_COEFF_MID],
      regs_ff[OFS_OFFSET_COEFF_LOW]};
   assign gain_coeff = {regs_ff[OFS_GAIN_COEFF_HIGH], regs_ff[OFS_GAIN_COEFF_MID], regs_ff[OFS_GAIN_COEFF_LOW]};
   assign gpio_out = regs_ff[OFS_GPIO_VALUE][GPIO_WIDTH-1:0];
   assign gpio_oe = ~regs_ff[OFS_GPIO_DIRECTION][GPIO_WIDTH-1:0];
endmodule

// ### design/acrb_pkg.sv
// package: register offsets, reset values and field positions for the config register and ram banks
package acrb_pkg;
   localparam logic [3:0] OFS_SETUP_CONFIG = 4'h0;
   localparam logic [3:0] OFS_INPUT_SELECT = 4'h1;
   localparam logic [3:0] OFS_ANALOG_CONTROL = 4'h2;
   localparam logic [3:0] OFS_CURRENT_SOURCE_ONE_CODE = 4'h3;
   localparam logic [3:0] OFS_CURRENT_SOURCE_TWO_CODE = 4'h4;
   localparam logic [3:0] OFS_INPUT_OFFSET_SETTING = 4'h5;
   localparam logic [3:0] OFS_GPIO_VALUE = 4'h6;
   localparam logic [3:0] OFS_GPIO_DIRECTION = 4'h7;
   localparam logic [3:0] OFS_DECIMATION_LOW = 4'h8;
   localparam logic [3:0] OFS_MODE_DECIMATION_HIGH = 4'h9;
   localparam logic [3:0] OFS_OFFSET_COEFF_LOW = 4'hA;
   localparam logic [3:0] OFS_OFFSET_COEFF_MID = 4'hB;
   localparam logic [3:0] OFS_OFFSET_COEFF_HIGH = 4'hC;
   localparam logic [3:0] OFS_GAIN_COEFF_LOW = 4'hD;
   localparam logic [3:0] OFS_GAIN_COEFF_MID = 4'hE;
   localparam logic [3:0] OFS_GAIN_COEFF_HIGH = 4'hF;
   localparam int NUM_REGS = 16;
   localparam int NUM_BANKS = 8;
   localparam int RAM_BYTES = 128;
   // reset values; setup bits 7-5 come from the factory id input
   localparam logic [4:0] RST_SETUP_LOW = 5'h0E;
   localparam logic [7:0] RST_INPUT_SELECT = 8'h01;
   localparam logic [7:0] RST_ZERO = 8'h00;
   localparam logic [7:0] RST_GPIO_DIRECTION = 8'hFF;
   localparam logic [7:0] RST_DECIMATION_LOW = 8'h80;
   localparam logic [7:0] RST_MODE_DECIMATION_HIGH = 8'h07;
   localparam logic [7:0] RST_GAIN_COEFF_LOW = 8'h24;
   localparam logic [7:0] RST_GAIN_COEFF_MID = 8'h90;
   localparam logic [7:0] RST_GAIN_COEFF_HIGH = 8'h67;
   // field positions
   localparam int SETUP_ID_LSB = 5;
   localparam int SETUP_SPEED_BIT = 4;
   localparam int SETUP_REF_EN_BIT = 3;
   localparam int SETUP_REF_LEVEL_BIT = 2;
   localparam int SETUP_BUF_EN_BIT = 1;
   localparam int SETUP_BIT_ORDER_BIT = 0;
   localparam int MODE_DATA_READY_BIT = 7;
   localparam int MODE_RESERVED_BIT = 3;
   // modulator clock division
   localparam logic [8:0] MOD_DIV_SLOW = 9'd256;
   localparam logic [8:0] MOD_DIV_FAST = 9'd128;
   // burst checksum operations
   localparam logic [1:0] CSUM_ONE_BANK = 2'd0;
   localparam logic [1:0] CSUM_ALL_BANKS = 2'd1;
   localparam logic [1:0] CSUM_REGS = 2'd2;
   // input mux codes
   localparam logic [3:0] MUX_DIODE = 4'hF;
   typedef enum logic [1:0] {acrb_idle_e, acrb_copy_e, acrb_csum_e} acrb_state_e;
endpackage

// ### bench/acrb_config_banks_monitor.sv
// checker: timing and decode relations at the config bank ports
`timescale 1ns/1ps
module acrb_config_banks_monitor
   import acrb_pkg::*;
#(
   parameter int GPIO_WIDTH = 8
) (
   input logic sys_clk, // core clock
   input logic nrst, // async reset, active low
   input logic reg_wr, // register write strobe
   input logic [3:0] reg_addr, // register offset
   input logic [7:0] reg_wdata, // register write byte
   input logic ram_load_ptr, // pointer load
   input logic [7:0] ram_ptr_addr, // pointer load value
   input logic ram_wr, // ram write
   input logic ram_rd, // ram read
   input logic [7:0] ram_ptr, // linear pointer
   input logic copy_reg_to_ram, // copy to bank
   input logic copy_reg_to_all, // copy to all banks
   input logic copy_ram_to_reg, // copy from bank
   input logic csum_start, // checksum start
   input logic [7:0] csum_value, // checksum result
   input logic busy, // operation running
   input logic mod_div_256, // slow modulator clock
   input logic [8:0] mod_div, // divide ratio
   input logic [3:0] positive_input_select, // positive mux code
   input logic [3:0] pos_channel, // decoded channel
   input logic pos_common, // common input chosen
   input logic pos_diode_anode, // diode anode chosen
   input logic [2:0] gain_select, // gain code
   input logic [7:0] gain_value, // gain factor
   input logic [GPIO_WIDTH-1:0] gpio_oe // pin drive enables
);
   // ------------------------------------------------------------
   // bank operation timing
   // ------------------------------------------------------------
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!nrst);
   sequence s_op_req;
      (copy_reg_to_ram || copy_reg_to_all || copy_ram_to_reg || csum_start) && !busy;
   endsequence
   logic [7:0] busy_cnt_ff;
   // counts busy cycles; a bank move shorter than a whole bank would show here
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         busy_cnt_ff <= 8'h00;
      end else begin
         busy_cnt_ff <= busy ? busy_cnt_ff + 8'h01 : 8'h00;
      end
   end
   a_busy_start: assert property (s_op_req |=> busy) else $error("busy did not follow a request");
   a_busy_length: assert property ($fell(busy) |-> busy_cnt_ff == 8'd16 || busy_cnt_ff == 8'd128)
      else $error("operation length is not a whole bank or all banks");
   a_csum_moment: assert property ($changed(csum_value) |-> $past(busy))
      else $error("checksum changed with no operation running");
   a_ptr_advance: assert property ((ram_wr || ram_rd) && !busy && !ram_load_ptr |=>
      ram_ptr == {1'b0, $past(ram_ptr[6:0]) + 7'h01}) else $error("pointer did not advance by one");
   a_ptr_load: assert property (ram_load_ptr && !busy |=> ram_ptr == {1'b0, $past(ram_ptr_addr[6:0])})
      else $error("pointer load value wrong");
   a_ptr_range: assert property (ram_ptr[7] == 1'b0) else $error("pointer beyond 128 bytes");
   a_div_ratio: assert property (mod_div == (mod_div_256 ? MOD_DIV_SLOW : MOD_DIV_FAST))
      else $error("divide ratio does not match speed bit");
   a_pos_decode: assert property (pos_diode_anode == (positive_input_select == MUX_DIODE) &&
      pos_common == (positive_input_select[3] && !pos_diode_anode) &&
      (positive_input_select[3] || pos_channel == positive_input_select)) else $error("positive decode wrong");
   a_gain_decode: assert property (gain_value == 8'h01 << gain_select) else $error("gain decode wrong");
   a_dir_write: assert property (reg_wr && reg_addr == OFS_GPIO_DIRECTION && !busy |=>
      gpio_oe == ~$past(reg_wdata)) else $error("pin enables do not follow direction write");
endmodule
bind acrb_config_banks acrb_config_banks_monitor #(.GPIO_WIDTH(GPIO_WIDTH)) acrb_config_banks_monitor_inst (.*);

// ### bench/acrb_gpio_pads.sv
// gpio pad model: outside sources meet the pins driven by the block
`timescale 1ns/1ps
module acrb_gpio_pads (
   input logic [7:0] gpio_out, // value from the block
   input logic [7:0] gpio_oe, // high where the block drives
   input logic [7:0] ext_level, // outside source level
   output logic [7:0] pin_level // resolved pin level
);
   // undriven pins follow the outside source, never the stale block value
   assign pin_level = (gpio_oe & gpio_out) | (~gpio_oe & ext_level);
endmodule

// ### bench/testbench.sv
// self-checking bench for the config register and ram banks
`timescale 1ns/1ps
module testbench;
   import acrb_pkg::*;
   logic sys_clk, nrst, data_ready_n, reg_wr, reg_rd, ram_load_ptr, ram_wr, ram_rd, busy, mod_div_256;
   logic copy_reg_to_ram, copy_reg_to_all, copy_ram_to_reg, csum_start, ref_enable, reference_level_select;
   logic buffer_enable, out_lsb_first, pos_common, pos_diode_anode, neg_common, neg_diode_cathode;
   logic burnout_source_on, offset_negative, unipolar;
   logic [1:0] csum_kind, source_two_range, source_one_range, settling_filter_select;
   logic [2:0] factory_id, op_bank, gain_select;
   logic [3:0] reg_addr, positive_input_select, negative_input_select, pos_channel, neg_channel;
   logic [6:0] offset_magnitude;
   logic [7:0] reg_wdata, reg_rdata, ram_ptr_addr, ram_wdata, ram_rdata, ram_ptr, csum_value, gain_value;
   logic [7:0] current_source_one_code, current_source_two_code, gpio_in, gpio_out, gpio_oe, ext_level;
   logic [8:0] mod_div;
   logic [10:0] decimation;
   logic [23:0] offset_coeff, gain_coeff;
   logic [7:0] rm [16];
   int n_errors, checks_done, cycles;
   acrb_config_banks #(.GPIO_WIDTH(8)) acrb_config_banks_inst (.*);
   acrb_gpio_pads acrb_gpio_pads_inst (.gpio_out(gpio_out), .gpio_oe(gpio_oe), .ext_level(ext_level),
      .pin_level(gpio_in));
   initial begin
      sys_clk = 1'b0;
      forever #12.5 sys_clk = ~sys_clk;
   end
   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------
   task automatic final_report;
      $display("checks done %0d, mismatches %0d", checks_done, n_errors);
      if (n_errors == 0 && checks_done > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   always @(posedge sys_clk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         n_errors++;
         $display("mismatch at %0t: run did not finish in time", $time);
         final_report();
      end
   end
   task automatic chk(input logic [47:0] got, input logic [47:0] exp, input string what);
      checks_done++;
      if (got !== exp) begin
         n_errors++;
         $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask
   function automatic logic [7:0] pat(input int i);
      return 8'(i * 7 + 3);
   endfunction
   function automatic logic [7:0] ram_sum(input int lo, input int n, input bit regs);
      logic [7:0] s;
      s = 8'h00;
      for (int i = lo; i < lo + n; i++) begin
         s += regs ? rm[i] : pat(i);
      end
      return s;
   endfunction
   // id bits, pin levels and the ready flag read live, not the stored byte
   function automatic logic [7:0] vis(input int a);
      case (a)
         0: vis = {factory_id, rm[0][4:0]};
         6: vis = (~rm[7] & rm[6]) | (rm[7] & ext_level);
         9: vis = {~data_ready_n, rm[9][6:0]};
         default: vis = rm[a];
      endcase
   endfunction
   task automatic reg_op(input logic wr, input logic [3:0] a, input logic [7:0] d);
      @(posedge sys_clk);
      reg_wr <= wr;
      reg_rd <= ~wr;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge sys_clk);
      {reg_wr, reg_rd} <= 2'b00;
      #1;
   endtask
   // kind 0 loads the pointer, 1 writes a byte, 2 reads a byte
   task automatic ram_op(input int kind, input logic [7:0] d);
      @(posedge sys_clk);
      ram_load_ptr <= kind == 0;
      ram_wr <= kind == 1;
      ram_rd <= kind == 2;
      ram_ptr_addr <= d;
      ram_wdata <= d;
      @(posedge sys_clk);
      {ram_load_ptr, ram_wr, ram_rd} <= 3'b000;
      #1;
   endtask
   // kinds 0-2 copy to bank, to all, from bank; 3-5 checksum bank, all ram, registers
   task automatic op_start(input int kind, input logic [2:0] b);
      @(posedge sys_clk);
      copy_reg_to_ram <= kind == 0;
      copy_reg_to_all <= kind == 1;
      copy_ram_to_reg <= kind == 2;
      csum_start <= kind >= 3;
      csum_kind <= 2'(kind - 3);
      op_bank <= b;
      @(posedge sys_clk);
      {copy_reg_to_ram, copy_reg_to_all, copy_ram_to_reg, csum_start} <= 4'h0;
      #1;
      chk(busy, 1'b1, "busy after start");
   endtask
   task automatic op_wait;
      for (int i = 0; i < 300 && busy !== 1'b0; i++) begin
         @(posedge sys_clk);
         #1;
      end
      chk(busy, 1'b0, "operation finished");
   endtask
   task automatic check_regs;
      for (int a = 0; a < 16; a++) begin
         reg_op(1'b0, 4'(a), 8'h00);
         chk(reg_rdata, vis(a), "register readback");
      end
   endtask
   // ------------------------------------------------------------
   // tests
   // ------------------------------------------------------------
   initial begin
      {nrst, reg_wr, reg_rd, ram_load_ptr, ram_wr, ram_rd, reg_addr, reg_wdata} = '0;
      {copy_reg_to_ram, copy_reg_to_all, copy_ram_to_reg, csum_start, ram_ptr_addr, ram_wdata} = '0;
      {op_bank, csum_kind} = '0;
      data_ready_n = 1'b1;
      factory_id = 3'h5; // arbitrary strap value
      ext_level = 8'h3C;
      repeat (3) @(posedge sys_clk);
      nrst <= 1'b1;
      rm = '{8'(RST_SETUP_LOW), RST_INPUT_SELECT, RST_ZERO, RST_ZERO, RST_ZERO, RST_ZERO, RST_ZERO,
         RST_GPIO_DIRECTION, RST_DECIMATION_LOW, RST_MODE_DECIMATION_HIGH, RST_ZERO, RST_ZERO, RST_ZERO,
         RST_GAIN_COEFF_LOW, RST_GAIN_COEFF_MID, RST_GAIN_COEFF_HIGH};
      check_regs();
      chk({ref_enable, reference_level_select, buffer_enable}, 3'b111, "reference defaults");
      chk(mod_div, MOD_DIV_FAST, "divider default");
      chk(gpio_oe, 8'h00, "pins start as inputs");
      $display("test reset values done");
      for (int a = 0; a < 16; a++) begin
         rm[a] = 8'(a * 29 + 8'hB6);
         reg_op(1'b1, 4'(a), rm[a]);
      end
      data_ready_n <= 1'b0;
      repeat (8) @(posedge sys_clk);
      check_regs();
      chk(gpio_oe, 8'(~rm[7]), "pin enables");
      chk(gpio_out, rm[6], "pin values");
      chk(mod_div, rm[0][4] ? MOD_DIV_SLOW : MOD_DIV_FAST, "divider");
      chk({ref_enable, reference_level_select, buffer_enable, out_lsb_first}, rm[0][3:0], "setup");
      chk({burnout_source_on, source_two_range, source_one_range}, rm[2][7:3], "analog control");
      chk({current_source_one_code, current_source_two_code}, {rm[3], rm[4]}, "dac codes");
      chk({offset_negative, offset_magnitude}, rm[5], "offset dac");
      chk({offset_coeff, gain_coeff}, {rm[12], rm[11], rm[10], rm[15], rm[14], rm[13]}, "calibration words");
      chk({unipolar, settling_filter_select, decimation}, {rm[9][6:4], rm[9][2:0], rm[8]}, "mode and decimation");
      $display("test register writes done");
      for (int c = 0; c < 16; c++) begin
         reg_op(1'b1, OFS_INPUT_SELECT, {4'(c), 4'(15 - c)});
         chk({pos_diode_anode, pos_common, neg_diode_cathode, neg_common},
            {c == 15, c > 7 && c < 15, c == 0, c > 0 && c < 8}, "mux decode");
         chk({pos_channel, neg_channel}, {4'(c % 8), 4'((15 - c) % 8)}, "mux channel");
      end
      for (int g = 0; g < 8; g++) begin
         reg_op(1'b1, OFS_ANALOG_CONTROL, 8'(g));
         chk(gain_value, 16'(1 << g), "gain");
      end
      rm[1] = 8'hF0;
      rm[2] = 8'h07;
      $display("test decodes done");
      ram_op(0, 8'h00);
      for (int i = 0; i < 128; i++) begin
         ram_op(1, pat(i));
      end
      chk(ram_ptr, 8'h00, "pointer after full sweep");
      ram_op(0, 8'h0F);
      ram_op(2, 8'h00);
      chk(ram_rdata, pat(15), "last byte of bank 0");
      ram_op(2, 8'h00);
      chk(ram_rdata, pat(16), "first byte of bank 1");
      ram_op(0, 8'h7F);
      ram_op(2, 8'h00);
      chk(ram_rdata, pat(127), "last byte of bank 7");
      chk(ram_ptr, 8'h00, "pointer wrap");
      $display("test ram pointer done");
      op_start(4, 3'h0);
      op_wait();
      chk(csum_value, ram_sum(0, 128, 1'b0), "checksum of all ram");
      op_start(3, 3'h3);
      op_wait();
      chk(csum_value, ram_sum(48, 16, 1'b0), "checksum of bank 3");
      op_start(5, 3'h0);
      op_wait();
      chk(csum_value, ram_sum(0, 16, 1'b1), "checksum of registers");
      $display("test checksums done");
      op_start(2, 3'h2);
      op_wait();
      for (int a = 0; a < 16; a++) begin
         rm[a] = pat(32 + a);
      end
      repeat (8) @(posedge sys_clk);
      check_regs();
      op_start(1, 3'h0);
      // a write landing in the middle of the copy must be dropped
      reg_op(1'b1, OFS_CURRENT_SOURCE_ONE_CODE, ~rm[3]);
      op_wait();
      check_regs();
      ram_op(0, 8'h74);
      ram_op(2, 8'h00);
      chk(ram_rdata, rm[4], "copy to all banks");
      op_start(0, 3'h5);
      op_wait();
      ram_op(0, 8'h51);
      for (int a = 1; a < 9; a++) begin
         ram_op(2, 8'h00);
         chk(ram_rdata, rm[a], "copy to bank 5");
      end
      $display("test bank copies done");
      final_report();
   end
endmodule
